//--- core/vpwl_link.sv
// Summary of operation
// - any chip reset source forces reset mode from every mode.
// - in reset mode registers take reset values, inputs are ignored; the register bus handshake is not reset and still answers reads and writes.
// - leave reset mode for run only after all reset sources drop.
// - wait instruction with select clear enters wait, clocks keep running.
// - stop, or wait with select set, enters stop and halts clocks.
// - in wait, first passive-to-active edge raises wake request, back to run.
// - in wait, a valid end of frame also raises a wake request.
// - in stop, bus activity raises wake request and restarts clocks.
// - digital loopback ties transmit to receive, bus not driven.
// - analog loopback keeps digital paths; after exit wait for idle bus.
// - filter samples on mux clock rise, steps on following fall.
// - counter counts up on high, down on low, saturates at 15 and 0.
// - counter at 15 sets the filtered output to one.
// - counter at 0 clears the filtered output to zero.
// - filtered output holds until the opposite end point.
// - clean edge reaches filtered output after 15 to 16 filter clocks.
// - inside a frame, filtered pulse shorter than shortest symbol flags invalid symbol.
// - frame holds at most 12 bytes.
// - every frame starts with a long active start symbol.
// - start symbol is kept out of the check-sum.
// - bus idle after inter-frame separation of 300 us expires.
`timescale 1ns/10ps
`default_nettype none
module vpwl_link #(
   parameter int MUX_DIV = vpwl_pkg::MUX_DIV
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // chip reset sources
   input wire logic i_low_voltage_reset,
   input wire logic i_power_on_reset,
   input wire logic i_watchdog_reset_source,
   input wire logic i_reset_pin,
   // cpu power instructions
   input wire logic i_cpu_wait,
   input wire logic i_cpu_stop,
   // physical interface
   input wire logic i_rx_digital_in,
   output logic o_tx_digital_out,
   // power control
   output logic o_wake_req,
   output logic o_clk_run,
   // axi4-lite write address
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [7:0] i_awaddr,
   // axi4-lite write data
   input wire logic i_wvalid,
   output logic o_wready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   // axi4-lite write response
   output logic o_bvalid,
   input wire logic i_bready,
   output logic [1:0] o_bresp,
   // axi4-lite read address
   input wire logic i_arvalid,
   output logic o_arready,
   input wire logic [7:0] i_araddr,
   // axi4-lite read data
   output logic o_rvalid,
   input wire logic i_rready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp
);
   // ----------------------------------------
   // declarations
   // ----------------------------------------
   vpwl_pkg::vpwl_mode_e mode_reg;
   vpwl_pkg::vpwl_ctrl_s ctrl_reg;
   logic hold, rise_tick, fall_tick, rx_src, samp_reg, fedge;
   logic filt_out_reg, filt_prev_reg, idle_reg, in_frame_reg, crc_win_reg;
   logic eof_ev, sof_ev, inv_ev, wake_ev, ovf_ev, ana_prev_reg, await_idle_reg;
   logic aw_held_reg, w_held_reg, wr_do, rd_ok;
   logic [3:0] filt_reg, byte_cnt_reg, wstrb_reg;
   logic [4:0] flag_reg;
   logic [7:0] div_reg, txb_reg, waddr_reg;
   logic [31:0] wdata_reg, rd_word;
   logic [vpwl_pkg::RUN_W-1:0] run_reg;
   function automatic logic [vpwl_pkg::RUN_W-1:0] sat_inc(
      input logic [vpwl_pkg::RUN_W-1:0] v
   );
      sat_inc = (&v) ? v : v + 1'b1;
   endfunction : sat_inc
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == vpwl_pkg::OFS_CTRL) || (a == vpwl_pkg::OFS_STAT) ||
         (a == vpwl_pkg::OFS_FLAG) || (a == vpwl_pkg::OFS_TXB) ||
         (a == vpwl_pkg::OFS_FILT);
   endfunction : mapped

   // ----------------------------------------
   // operating mode
   // ----------------------------------------
   assign hold = i_low_voltage_reset | i_power_on_reset |
      i_watchdog_reset_source | i_reset_pin;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         mode_reg <= vpwl_pkg::MODE_RESET;
      end else if (hold) begin
         mode_reg <= vpwl_pkg::MODE_RESET;
      end else begin
         unique case (mode_reg)
            vpwl_pkg::MODE_RESET: mode_reg <= vpwl_pkg::MODE_RUN;
            vpwl_pkg::MODE_RUN: begin
               if (i_cpu_stop ||
                  (i_cpu_wait && ctrl_reg.wait_clock_stop_select)) begin
                  mode_reg <= vpwl_pkg::MODE_STOP;
               end else if (i_cpu_wait) begin
                  mode_reg <= vpwl_pkg::MODE_WAIT;
               end
            end
            vpwl_pkg::MODE_WAIT, vpwl_pkg::MODE_STOP: begin
               if (wake_ev) begin
                  mode_reg <= vpwl_pkg::MODE_RUN;
               end
            end
         endcase
      end
   end

   // wake on first active edge or end of frame in wait, raw activity in stop
   assign wake_ev = ((mode_reg == vpwl_pkg::MODE_WAIT) && ((fedge && !filt_out_reg) || eof_ev)) ||
      ((mode_reg == vpwl_pkg::MODE_STOP) && (rx_src != vpwl_pkg::LVL_PASSIVE));

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_wake_req <= 1'b0;
      end else begin
         o_wake_req <= wake_ev & ~hold;
      end
   end
   assign o_clk_run = (mode_reg != vpwl_pkg::MODE_STOP);

   // ----------------------------------------
   // mux interface clock
   // ----------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         div_reg <= 8'h00;
      end else if (hold || !o_clk_run) begin
         div_reg <= 8'h00;
      end else if (div_reg == 8'(MUX_DIV - 1)) begin
         div_reg <= 8'h00;
      end else begin
         div_reg <= div_reg + 8'h01;
      end
   end
   assign rise_tick = o_clk_run && (div_reg == 8'h00);
   assign fall_tick = o_clk_run && (div_reg == 8'(MUX_DIV / 2));

   // ----------------------------------------
   // loopback and transmit
   // ----------------------------------------
   assign rx_src = ctrl_reg.dig_loop ? ctrl_reg.tx_level : i_rx_digital_in;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ana_prev_reg <= 1'b0;
         await_idle_reg <= 1'b0;
      end else if (hold) begin
         ana_prev_reg <= 1'b0;
         await_idle_reg <= 1'b0;
      end else begin
         ana_prev_reg <= ctrl_reg.ana_loop;
         if (ana_prev_reg && !ctrl_reg.ana_loop) begin
            await_idle_reg <= 1'b1;
         end else if (idle_reg) begin
            await_idle_reg <= 1'b0;
         end
      end
   end

   // bus left passive in digital loopback and while waiting for idle
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_tx_digital_out <= vpwl_pkg::LVL_PASSIVE;
      end else if (hold || ctrl_reg.dig_loop || await_idle_reg) begin
         o_tx_digital_out <= vpwl_pkg::LVL_PASSIVE;
      end else begin
         o_tx_digital_out <= ctrl_reg.tx_level;
      end
   end

   // ----------------------------------------
   // receive noise filter
   // ----------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         samp_reg <= vpwl_pkg::LVL_PASSIVE;
      end else if (hold) begin
         samp_reg <= vpwl_pkg::LVL_PASSIVE;
      end else if (rise_tick) begin
         samp_reg <= rx_src;
      end
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         filt_reg <= vpwl_pkg::FILT_TOP;
      end else if (hold) begin
         filt_reg <= vpwl_pkg::FILT_TOP;
      end else if (fall_tick) begin
         if (samp_reg && filt_reg != vpwl_pkg::FILT_TOP) begin
            filt_reg <= filt_reg + 4'h1;
         end else if (!samp_reg && filt_reg != vpwl_pkg::FILT_BOT) begin
            filt_reg <= filt_reg - 4'h1;
         end
      end
   end
   // latch changes only at the end points, giving 15 to 16 period delay
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         filt_out_reg <= 1'b1;
         filt_prev_reg <= 1'b1;
      end else if (hold) begin
         filt_out_reg <= 1'b1;
         filt_prev_reg <= 1'b1;
      end else begin
         filt_prev_reg <= filt_out_reg;
         if (filt_reg == vpwl_pkg::FILT_TOP) begin
            filt_out_reg <= 1'b1;
         end else if (filt_reg == vpwl_pkg::FILT_BOT) begin
            filt_out_reg <= 1'b0;
         end
      end
   end
   assign fedge = filt_out_reg != filt_prev_reg;

   // ----------------------------------------
   // symbol timing on the filtered signal
   // ----------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         run_reg <= '0;
      end else if (hold || fedge) begin
         run_reg <= '0;
      end else begin
         run_reg <= sat_inc(run_reg);
      end
   end
   assign inv_ev = fedge && in_frame_reg &&
      (run_reg < vpwl_pkg::RUN_W'(vpwl_pkg::SYM_MIN_CYC));
   assign sof_ev = fedge && filt_out_reg && !in_frame_reg &&
      (run_reg >= vpwl_pkg::RUN_W'(vpwl_pkg::SOF_CYC));
   assign eof_ev = in_frame_reg && filt_out_reg &&
      (run_reg == vpwl_pkg::RUN_W'(vpwl_pkg::EOF_CYC));
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         in_frame_reg <= 1'b0;
         crc_win_reg <= 1'b0;
         idle_reg <= 1'b1;
      end else if (hold) begin
         in_frame_reg <= 1'b0;
         crc_win_reg <= 1'b0;
         idle_reg <= 1'b1;
      end else begin
         if (sof_ev) begin
            in_frame_reg <= 1'b1;
            crc_win_reg <= 1'b1;
         end else if (eof_ev) begin
            in_frame_reg <= 1'b0;
            crc_win_reg <= 1'b0;
         end
         if (!filt_out_reg) begin
            idle_reg <= 1'b0;
         end else if (run_reg >= vpwl_pkg::RUN_W'(vpwl_pkg::IFS_CYC)) begin
            idle_reg <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // frame bytes and sticky flags
   // ----------------------------------------
   assign ovf_ev = wr_do && (waddr_reg == vpwl_pkg::OFS_TXB) &&
      (byte_cnt_reg == 4'(vpwl_pkg::MAX_FRAME_BYTES));
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         txb_reg <= 8'h00;
         byte_cnt_reg <= 4'h0;
      end else if (hold || eof_ev) begin
         txb_reg <= 8'h00;
         byte_cnt_reg <= 4'h0;
      end else if (wr_do && waddr_reg == vpwl_pkg::OFS_TXB && !ovf_ev &&
         wstrb_reg[0]) begin
         txb_reg <= wdata_reg[7:0];
         byte_cnt_reg <= byte_cnt_reg + 4'h1;
      end
   end

   // set wins over write-one-to-clear
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         flag_reg <= 5'h00;
      end else if (hold) begin
         flag_reg <= 5'h00;
      end else begin
         flag_reg <= (flag_reg & ~((wr_do && waddr_reg == vpwl_pkg::OFS_FLAG &&
            wstrb_reg[0]) ? wdata_reg[4:0] : 5'h00)) |
            {ovf_ev, sof_ev, inv_ev, eof_ev, wake_ev};
      end
   end

   // ----------------------------------------
   // axi4-lite write
   // ----------------------------------------
   assign o_awready = !aw_held_reg;
   assign o_wready = !w_held_reg;
   assign wr_do = aw_held_reg && w_held_reg && !o_bvalid;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         waddr_reg <= 8'h00;
         wdata_reg <= 32'h0;
         wstrb_reg <= 4'h0;
      end else begin
         if (i_awvalid && o_awready) begin
            aw_held_reg <= 1'b1;
            waddr_reg <= {i_awaddr[7:2], 2'b00};
         end else if (wr_do) begin
            aw_held_reg <= 1'b0;
         end
         if (i_wvalid && o_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= i_wdata;
            wstrb_reg <= i_wstrb;
         end else if (wr_do) begin
            w_held_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_bvalid <= 1'b0;
         o_bresp <= vpwl_pkg::RESP_OKAY;
      end else if (wr_do) begin
         o_bvalid <= 1'b1;
         o_bresp <= mapped(waddr_reg) ? vpwl_pkg::RESP_OKAY : vpwl_pkg::RESP_SLVERR;
      end else if (i_bready) begin
         o_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ctrl_reg <= vpwl_pkg::CTRL_RST;
      end else if (hold) begin
         ctrl_reg <= vpwl_pkg::CTRL_RST;
      end else if (wr_do && waddr_reg == vpwl_pkg::OFS_CTRL && wstrb_reg[0]) begin
         ctrl_reg <= wdata_reg[3:0];
      end
   end

   // ----------------------------------------
   // axi4-lite read
   // ----------------------------------------
   assign o_arready = !o_rvalid;
   always_comb begin
      rd_word = 32'h0;
      rd_ok = 1'b1;
      unique case ({i_araddr[7:2], 2'b00})
         vpwl_pkg::OFS_CTRL: rd_word = {28'h0, ctrl_reg};
         vpwl_pkg::OFS_STAT: rd_word = {26'h0, crc_win_reg, await_idle_reg,
            idle_reg, filt_out_reg, mode_reg};
         vpwl_pkg::OFS_FLAG: rd_word = {27'h0, flag_reg};
         vpwl_pkg::OFS_TXB: rd_word = {20'h0, byte_cnt_reg, txb_reg};
         vpwl_pkg::OFS_FILT: rd_word = {28'h0, filt_reg};
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rvalid <= 1'b0;
         o_rdata <= 32'h0;
         o_rresp <= vpwl_pkg::RESP_OKAY;
      end else if (i_arvalid && o_arready) begin
         o_rvalid <= 1'b1;
         o_rdata <= rd_word;
         o_rresp <= rd_ok ? vpwl_pkg::RESP_OKAY : vpwl_pkg::RESP_SLVERR;
      end else if (i_rready) begin
         o_rvalid <= 1'b0;
      end
   end
endmodule : vpwl_link
`default_nettype wire

//--- pkg/vpwl_pkg.sv
package vpwl_pkg;
   // ----------------------------------------
   // clock and timing
   // ----------------------------------------
   localparam int CLK_HZ = 10_000_000;
   localparam int CLK_MHZ = CLK_HZ / 1_000_000;
   localparam int SOF_US = 200;
   localparam int EOF_US = 280;
   localparam int IFS_US = 300;
   localparam int SYM_MIN_US = 64;
   localparam int SOF_CYC = SOF_US * CLK_MHZ;
   localparam int EOF_CYC = EOF_US * CLK_MHZ;
   localparam int IFS_CYC = IFS_US * CLK_MHZ;
   localparam int SYM_MIN_CYC = SYM_MIN_US * CLK_MHZ;
   localparam int MUX_DIV = 10;
   localparam int RUN_W = 12;
   localparam int MAX_FRAME_BYTES = 12;
   // ----------------------------------------
   // filter
   // ----------------------------------------
   localparam logic [3:0] FILT_TOP = 4'hf;
   localparam logic [3:0] FILT_BOT = 4'h0;
   localparam logic LVL_PASSIVE = 1'b1;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_FLAG = 8'h08;
   localparam logic [7:0] OFS_TXB = 8'h0c;
   localparam logic [7:0] OFS_FILT = 8'h10;
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam int FLG_WAKE = 0;
   localparam int FLG_EOF = 1;
   localparam int FLG_INV = 2;
   localparam int FLG_SOF = 3;
   localparam int FLG_OVF = 4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {
      MODE_RESET = 2'h0,
      MODE_RUN = 2'h1,
      MODE_WAIT = 2'h3,
      MODE_STOP = 2'h2
   } vpwl_mode_e;
   typedef struct packed {
      logic tx_level;
      logic ana_loop;
      logic dig_loop;
      logic wait_clock_stop_select;
   } vpwl_ctrl_s;
endpackage : vpwl_pkg

//--- testbench/vpwl_link_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module vpwl_link_checker (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // chip reset sources and bus level
   input wire logic i_low_voltage_reset,
   input wire logic i_power_on_reset,
   input wire logic i_watchdog_reset_source,
   input wire logic i_reset_pin,
   input wire logic i_rx_digital_in,
   // link outputs
   input wire logic o_tx_digital_out,
   input wire logic o_wake_req,
   input wire logic o_clk_run,
   // register bus
   input wire logic i_awvalid,
   input wire logic o_awready,
   input wire logic i_wvalid,
   input wire logic o_wready,
   input wire logic o_bvalid,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic o_rvalid,
   input wire logic i_rready,
   input wire logic [31:0] o_rdata
);
   // ----------------------------------------
   // mode and bus checks
   // ----------------------------------------
   wire logic src;
   assign src = i_low_voltage_reset | i_power_on_reset
      | i_watchdog_reset_source | i_reset_pin;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   a_src_from_stop: assert property (src && !o_clk_run |=> o_clk_run)
      else $error("reset source did not leave stop mode");
   a_src_quiet: assert property (src [*2] |=> o_tx_digital_out && !o_wake_req)
      else $error("outputs not in reset state under reset source");
   a_stop_wake: assert property (!o_clk_run && !i_rx_digital_in && !src |=>
      o_clk_run && o_wake_req)
      else $error("bus activity in stop did not wake");
   a_stop_hold: assert property (!o_clk_run && i_rx_digital_in && !src |=> !o_clk_run)
      else $error("stop mode left without bus activity");
   a_wake_single: assert property (o_wake_req |=> !o_wake_req)
      else $error("wake request longer than one cycle");
   a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
      else $error("read data not one cycle after address");
   a_read_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read data dropped before taken");
   a_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready
      |=> ##1 o_bvalid)
      else $error("write response late");
endmodule : vpwl_link_checker
`default_nettype wire

//--- testbench/vpwl_xcvr_model.sv
`timescale 1ns/10ps
`default_nettype none
module vpwl_xcvr_model (
   // from the link and the other nodes, 0 = active
   input wire logic i_tx_digital_out,
   input wire logic i_peer_level,
   // to the link
   output logic o_rx_digital_in
);
   // pulled-up bus: passive unless some node drives it active
   assign o_rx_digital_in = i_tx_digital_out & i_peer_level;
endmodule : vpwl_xcvr_model
`default_nettype wire

//--- testbench/vpw_link_modes_rx_filter_bench.sv
`timescale 1ns/10ps
`default_nettype none
module vpw_link_modes_rx_filter_bench;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   localparam int LIMIT = 20000;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] srcs = 4'h0;
   logic cpu_wait = 1'b0;
   logic cpu_stop = 1'b0;
   logic peer = 1'b1;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic arvalid = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic rx, tx, wake, clk_run, awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, last_resp;
   logic [31:0] rdata, r;
   logic [31:0] seed = 32'h8;
   int mismatches = 0;
   int checks = 0;
   int cycles = 0;
   always #50 clk = ~clk;
   vpwl_link #(.MUX_DIV(2)) i_vpwl_link (
      .i_clk(clk), .i_rst(rst), .i_low_voltage_reset(srcs[0]), .i_power_on_reset(srcs[1]),
      .i_watchdog_reset_source(srcs[2]), .i_reset_pin(srcs[3]), .i_cpu_wait(cpu_wait),
      .i_cpu_stop(cpu_stop), .i_rx_digital_in(rx), .o_tx_digital_out(tx), .o_wake_req(wake),
      .o_clk_run(clk_run), .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
      .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'hf),
      .o_bvalid(bvalid), .i_bready(1'b1), .o_bresp(bresp), .i_arvalid(arvalid),
      .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(1'b1),
      .o_rdata(rdata), .o_rresp(rresp));
   vpwl_xcvr_model i_vpwl_xcvr_model (
      .i_tx_digital_out(tx), .i_peer_level(peer), .o_rx_digital_in(rx));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   function automatic logic [31:0] txb_exp(input logic [7:0] b, input logic [3:0] n);
      return {20'h0, n, b};
   endfunction : txb_exp
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      forever begin
         @(posedge clk);
         if (bvalid) break;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      last_resp = bresp;
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      araddr <= a;
      arvalid <= 1'b1;
      forever begin
         @(posedge clk);
         if (rvalid) break;
         if (arready) arvalid <= 1'b0;
      end
      last_resp = rresp;
      chk(rdata & m, e, "read");
   endtask : rdc
   task automatic cpu(input logic stp);
      if (stp) cpu_stop <= 1'b1;
      else cpu_wait <= 1'b1;
      @(posedge clk);
      cpu_stop <= 1'b0;
      cpu_wait <= 1'b0;
   endtask : cpu
   task automatic wait_wake();
      for (int n = 0; n < 80 && wake !== 1'b1; n++) @(posedge clk);
      chk(wake, 1'b1, "wake");
   endtask : wait_wake
   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         mismatches++;
         end_of_test();
      end
   end
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge clk);
      chk({tx, wake, clk_run}, 3'b101, "outputs in reset");
      rst <= 1'b0;
      rdc(vpwl_pkg::OFS_FILT, 32'hf, 32'hf);
      rdc(vpwl_pkg::OFS_STAT, 32'h7, 32'h5);
      rdc(vpwl_pkg::OFS_CTRL, 32'hf, 32'h0);
      rdc(8'h14, 32'h0, 32'h0);
      chk(last_resp, vpwl_pkg::RESP_SLVERR, "unmapped");
      wr(8'h14, 32'h1);
      chk(last_resp, vpwl_pkg::RESP_SLVERR, "unmapped write");
      wr(vpwl_pkg::OFS_CTRL, 32'h8);
      chk(last_resp, vpwl_pkg::RESP_OKAY, "mapped write");
      cyc(60);
      $display("test reset finished");
      peer <= 1'b0;
      cyc(22);
      rdc(vpwl_pkg::OFS_STAT, 32'h4, 32'h4);
      cyc(20);
      rdc(vpwl_pkg::OFS_STAT, 32'h4, 32'h0);
      rdc(vpwl_pkg::OFS_FILT, 32'hf, 32'h0);
      for (int i = 0; i < 4; i++) begin
         peer <= 1'b1;
         cyc(1 + rnd() % 20);
         peer <= 1'b0;
         cyc(40);
         rdc(vpwl_pkg::OFS_STAT, 32'h4, 32'h0);
      end
      peer <= 1'b1;
      cyc(22);
      rdc(vpwl_pkg::OFS_STAT, 32'h4, 32'h0);
      cyc(20);
      rdc(vpwl_pkg::OFS_STAT, 32'h4, 32'h4);
      rdc(vpwl_pkg::OFS_FILT, 32'hf, 32'hf);
      $display("test filter finished");
      wr(vpwl_pkg::OFS_CTRL, 32'h2);
      cyc(2);
      chk(tx, 1'b1, "tx in loopback");
      cyc(40);
      rdc(vpwl_pkg::OFS_STAT, 32'h4, 32'h0);
      wr(vpwl_pkg::OFS_CTRL, 32'h8);
      cyc(40);
      $display("test loopback finished");
      cpu(1'b0);
      cyc(2);
      rdc(vpwl_pkg::OFS_STAT, 32'h3, 32'h3);
      chk(clk_run, 1'b1, "clocks in wait");
      peer <= 1'b0;
      wait_wake();
      peer <= 1'b1;
      rdc(vpwl_pkg::OFS_STAT, 32'h3, 32'h1);
      rdc(vpwl_pkg::OFS_FLAG, 32'h1, 32'h1);
      wr(vpwl_pkg::OFS_FLAG, 32'h1);
      rdc(vpwl_pkg::OFS_FLAG, 32'h1, 32'h0);
      cyc(40);
      for (int k = 0; k < 2; k++) begin
         wr(vpwl_pkg::OFS_CTRL, k == 0 ? 32'h9 : 32'h8);
         cpu(k == 1);
         cyc(2);
         chk(clk_run, 1'b0, "clocks in stop");
         rdc(vpwl_pkg::OFS_STAT, 32'h3, 32'h2);
         peer <= 1'b0;
         wait_wake();
         chk(clk_run, 1'b1, "clocks after wake");
         peer <= 1'b1;
         wr(vpwl_pkg::OFS_FLAG, 32'h1);
         cyc(40);
      end
      $display("test power modes finished");
      for (int i = 0; i < 4; i++) begin
         wr(vpwl_pkg::OFS_CTRL, i % 2 ? 32'h8 : 32'h9);
         cpu(1'b0);
         srcs <= 4'h1 << i;
         cyc(2);
         rdc(vpwl_pkg::OFS_STAT, 32'h3, 32'h0);
         rdc(vpwl_pkg::OFS_CTRL, 32'hf, 32'h0);
         chk(tx, 1'b1, "tx under reset source");
         srcs <= 4'h0;
         cyc(2);
         rdc(vpwl_pkg::OFS_STAT, 32'h3, 32'h1);
         wr(vpwl_pkg::OFS_CTRL, 32'h8);
      end
      cyc(40);
      $display("test reset sources finished");
      for (int n = 1; n <= 12; n++) begin
         r = rnd();
         wr(vpwl_pkg::OFS_TXB, {24'h0, r[7:0]});
      end
      rdc(vpwl_pkg::OFS_TXB, 32'hfff, txb_exp(r[7:0], 4'hc));
      wr(vpwl_pkg::OFS_TXB, 32'h5a);
      rdc(vpwl_pkg::OFS_FLAG, 32'h10, 32'h10);
      rdc(vpwl_pkg::OFS_TXB, 32'hfff, txb_exp(r[7:0], 4'hc));
      wr(vpwl_pkg::OFS_FLAG, 32'h10);
      $display("test frame length finished");
      peer <= 1'b0;
      cyc(2100);
      peer <= 1'b1;
      cyc(60);
      rdc(vpwl_pkg::OFS_STAT, 32'h20, 32'h20);
      rdc(vpwl_pkg::OFS_FLAG, 32'h8, 32'h8);
      peer <= 1'b0;
      cyc(100);
      peer <= 1'b1;
      cyc(60);
      rdc(vpwl_pkg::OFS_FLAG, 32'h4, 32'h4);
      cpu(1'b0);
      cyc(2720);
      wait_wake();
      rdc(vpwl_pkg::OFS_STAT, 32'h23, 32'h1);
      rdc(vpwl_pkg::OFS_FLAG, 32'h2, 32'h2);
      rdc(vpwl_pkg::OFS_TXB, 32'hf00, 32'h0);
      wr(vpwl_pkg::OFS_FLAG, 32'h1f);
      $display("test frame symbols finished");
      wr(vpwl_pkg::OFS_CTRL, 32'hc);
      peer <= 1'b0;
      cyc(40);
      peer <= 1'b1;
      wr(vpwl_pkg::OFS_CTRL, 32'h0);
      cyc(1000);
      chk(tx, 1'b1, "tx before idle");
      rdc(vpwl_pkg::OFS_STAT, 32'h10, 32'h10);
      cyc(2600);
      chk(tx, 1'b0, "tx after idle");
      rdc(vpwl_pkg::OFS_STAT, 32'h10, 32'h0);
      wr(vpwl_pkg::OFS_CTRL, 32'h8);
      $display("test analog loopback finished");
      end_of_test();
   end
endmodule : vpw_link_modes_rx_filter_bench
bind vpwl_link vpwl_link_checker i_vpwl_link_checker (
   .i_clk, .i_rst, .i_low_voltage_reset, .i_power_on_reset, .i_watchdog_reset_source,
   .i_reset_pin, .i_rx_digital_in, .o_tx_digital_out, .o_wake_req, .o_clk_run, .i_awvalid,
   .o_awready, .i_wvalid, .o_wready, .o_bvalid, .i_arvalid, .o_arready, .o_rvalid, .i_rready,
   .o_rdata);
`default_nettype wire
